// file: src/gpb_pkg.sv
// Package with register map, field layout and reset values of the four-bit port.
package gpb_pkg;

   localparam int          GPB_PINS          = 4;
   localparam logic [11:0] GPB_OFS_LATCH     = 12'h001;
   localparam logic [11:0] GPB_OFS_DIR       = 12'h005;
   localparam logic [11:0] GPB_OFS_TIMCFG    = 12'h010;
   localparam int          GPB_DIR_CLKEN_BIT = 7;
   localparam logic [3:0]  GPB_DIR_RESET     = 4'h0;
   localparam logic        GPB_CLKEN_RESET   = 1'b0;
   localparam logic [1:0]  GPB_ELS_RESET     = 2'h0;
   localparam logic [2:0]  GPB_PS_RESET      = 3'h0;
   localparam logic [2:0]  GPB_PS_EXTCLK     = 3'h7;
   localparam int          GPB_TIMCFG_ELS_LSB = 0;
   localparam int          GPB_TIMCFG_PS_LSB  = 4;
   localparam int          GPB_CHAN_PIN      = 2;
   localparam int          GPB_TIMER_EXTERNAL_CLOCK_PIN_PIN      = 3;
   localparam int          GPB_MCLK_PIN      = 0;

endpackage

// file: src/gpb_pin_cell.sv
// One port pin: data latch, direction, output mux and read-back selection.
`timescale 1ns/1ps
module gpb_pin_cell
   import gpb_pkg::*;
(
   // Clock.
   input  wire logic core_clk,
   // Latch write.
   input  wire logic wr_latch,
   input  wire logic wdata,
   // Control.
   input  wire logic dir,
   input  wire logic alt_en,
   input  wire logic alt_out,
   input  wire logic alt_oe,
   // Pin.
   input  wire logic pin_in,
   output logic      pin_out,
   output logic      pin_oe,
   output logic      rd_bit
);

   logic latch_ff;

   // No reset on the latch, so system reset leaves its contents alone.
   always_ff @(posedge core_clk) begin
      if (wr_latch) begin
         latch_ff <= wdata;
      end
   end

   assign pin_out = alt_en ? alt_out : latch_ff;
   assign pin_oe  = alt_en ? alt_oe : dir;
   assign rd_bit  = dir ? latch_ff : pin_in;

endmodule // gpb_pin_cell

// file: src/gpb_clk_div.sv
// Half-rate bus clock for the clock output pin, toggling every core clock.
`timescale 1ns/1ps
module gpb_clk_div
   import gpb_pkg::*;
(
   // Clock and reset.
   input  wire logic core_clk,
   input  wire logic rst,
   // Enable and output.
   input  wire logic enable,
   output logic      clk_out
);

   logic div_ff;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         div_ff <= 1'b0;
      end else begin
         div_ff <= enable ? ~div_ff : 1'b0;
      end
   end

   assign clk_out = div_ff;

endmodule // gpb_clk_div

// file: src/gpb_port.sv
// Four-bit general-purpose port with APB register access and timer pin sharing.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module gpb_port
   import gpb_pkg::*;
(
   // Clock and reset.
   input  wire logic        core_clk,
   input  wire logic        rst,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Timer channel side.
   input  wire logic        tim_ch_out,
   input  wire logic        tim_ch_oe,
   output logic             tim_ch_in,
   output logic             tim_ext_clk,
   // Port pins.
   input  wire logic [3:0]  pin_in,
   output logic [3:0]       pin_out,
   output logic [3:0]       pin_oe
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers.
   logic [3:0]  dir_ff;
   logic        clken_ff;
   logic [1:0]  els_ff;
   logic [2:0]  ps_ff;
   logic [3:0]  pin_s_ff;
   logic [31:0] prdata_ff;
   logic        pready_ff;
   logic        pslverr_ff;
   logic [3:0]  pin_out_ff;
   logic [3:0]  pin_oe_ff;
   logic        tim_ch_in_ff;
   logic        tim_ext_clk_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Decode.
   wire        acc       = psel & penable & ~pready_ff;
   wire        hit_latch = (paddr == {GPB_OFS_LATCH[9:0], 2'b00});
   wire        hit_dir   = (paddr == {GPB_OFS_DIR[9:0], 2'b00});
   wire        hit_tim   = (paddr == {GPB_OFS_TIMCFG[9:0], 2'b00});
   wire        hit_any   = hit_latch | hit_dir | hit_tim;
   wire        wr        = acc & pwrite & hit_any;
   wire        wr_latch  = wr & hit_latch;
   wire        chan_sel  = (els_ff != 2'h0);
   wire        timer_external_clock_pin_sel  = (ps_ff == GPB_PS_EXTCLK);
   wire        mclk;
   wire [3:0]  cell_out;
   wire [3:0]  cell_oe;
   wire [3:0]  rd_bits;
   wire [3:0]  alt_en    = {1'b0, chan_sel, 1'b0, clken_ff};
   wire [3:0]  alt_out   = {1'b0, tim_ch_out, 1'b0, mclk};
   wire [3:0]  alt_oe    = {1'b0, tim_ch_oe, 1'b0, 1'b1};
   wire [31:0] rd_latch  = {28'h0, rd_bits};
   wire [31:0] rd_dir    = {24'h0, clken_ff, 3'h0, dir_ff};
   wire [31:0] rd_tim    = {25'h0, ps_ff, 2'h0, els_ff};
   wire [31:0] rd_mux    = hit_latch ? rd_latch : hit_dir ? rd_dir : hit_tim ? rd_tim : 32'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Pin cells and clock output.
   gpb_clk_div u_div (
      .core_clk (core_clk),
      .rst      (rst),
      .enable   (clken_ff),
      .clk_out  (mclk)
   );

   genvar gi;
   generate
      for (gi = 0; gi < GPB_PINS; gi++) begin : g_pin
         gpb_pin_cell u_cell (
            .core_clk (core_clk),
            .wr_latch (wr_latch),
            .wdata    (pwdata[gi]),
            .dir      (dir_ff[gi]),
            .alt_en   (alt_en[gi]),
            .alt_out  (alt_out[gi]),
            .alt_oe   (alt_oe[gi]),
            .pin_in   (pin_s_ff[gi]),
            .pin_out  (cell_out[gi]),
            .pin_oe   (cell_oe[gi]),
            .rd_bit   (rd_bits[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Control registers.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         dir_ff   <= GPB_DIR_RESET;
         clken_ff <= GPB_CLKEN_RESET;
         els_ff   <= GPB_ELS_RESET;
         ps_ff    <= GPB_PS_RESET;
      end else if (wr & hit_dir) begin
         dir_ff   <= pwdata[3:0];
         clken_ff <= pwdata[GPB_DIR_CLKEN_BIT];
      end else if (wr & hit_tim) begin
         els_ff   <= pwdata[GPB_TIMCFG_ELS_LSB +: 2];
         ps_ff    <= pwdata[GPB_TIMCFG_PS_LSB +: 3];
      end
   end

   // The sample register feeds input readback and the timer inputs, so both see the same level.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pin_s_ff <= 4'h0;
      end else begin
         pin_s_ff <= pin_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB answer, one wait state: ready the cycle after the first access cycle.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0;
      end else begin
         pready_ff  <= acc;
         pslverr_ff <= acc & ~hit_any;
         prdata_ff  <= (acc & ~pwrite) ? rd_mux : 32'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered pin and timer outputs; one cycle of lag is the price of glitch-free pins.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pin_out_ff     <= 4'h0;
         pin_oe_ff      <= 4'h0;
         tim_ch_in_ff   <= 1'b0;
         tim_ext_clk_ff <= 1'b0;
      end else begin
         pin_out_ff     <= cell_out;
         pin_oe_ff      <= cell_oe;
         tim_ch_in_ff   <= chan_sel & pin_s_ff[GPB_CHAN_PIN];
         tim_ext_clk_ff <= timer_external_clock_pin_sel & pin_s_ff[GPB_TIMER_EXTERNAL_CLOCK_PIN_PIN];
      end
   end

   assign prdata      = prdata_ff;
   assign pready      = pready_ff;
   assign pslverr     = pslverr_ff;
   assign pin_out     = pin_out_ff;
   assign pin_oe      = pin_oe_ff;
   assign tim_ch_in   = tim_ch_in_ff;
   assign tim_ext_clk = tim_ext_clk_ff;

endmodule // gpb_port

// file: dv/gpb_board.sv
// Board model: four pins driven either by the port or by outside circuitry.
`timescale 1ns/1ps
module gpb_board (
   // Pins.
   input  wire logic [3:0] pin_out,
   input  wire logic [3:0] pin_oe,
   input  wire logic [3:0] ext,
   output logic [3:0]      pin_in
);
   // Pins left floating show the outside level, which the bench changes at random.
   assign pin_in = (pin_out & pin_oe) | (ext & ~pin_oe);
endmodule // gpb_board

// file: dv/gpb_port_properties.sv
// Checker for the bus answer and pin enables of the four-bit port.
`timescale 1ns/1ps
module gpb_port_properties
   import gpb_pkg::*;
(
   // Clock, reset and bus.
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Pins.
   input wire logic [3:0]  pin_oe
);
   localparam logic [11:0] A_LAT = GPB_OFS_LATCH << 2;
   localparam logic [11:0] A_DIR = GPB_OFS_DIR << 2;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   sequence taken_s;
      psel && penable && !pready;
   endsequence
   sequence rd_s(logic [11:0] a);
      pready && !pwrite && paddr == a;
   endsequence
   AST_ANSWER: assert property (taken_s |=> pready) else $error("late answer");
   AST_PULSE: assert property (pready |=> !pready) else $error("long answer");
   AST_CAUSE: assert property (pready |-> $past(psel && penable)) else $error("stray answer");
   AST_ERR: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error");
   AST_IDLE: assert property (!pready |-> prdata == 32'h0) else $error("idle data");
   AST_LAT: assert property (rd_s(A_LAT) |-> prdata[31:4] == 28'h0 && !pslverr) else $error("port bits");
   AST_DIR: assert property (rd_s(A_DIR) |-> prdata[31:8] == 24'h0 && prdata[6:4] == 3'h0) else $error("dir");
   AST_RST: assert property ($fell(rst) |-> pin_oe == 4'h0 && !pready) else $error("pins after reset");
endmodule // gpb_port_properties
bind gpb_port gpb_port_properties gpb_port_properties_i (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_oe(pin_oe));

// file: dv/gpb_port_test.sv
// Self-checking bench for the four-bit port.
`timescale 1ns/1ps
module gpb_port_test;
   import gpb_pkg::*;
   localparam logic [11:0] A_LAT = GPB_OFS_LATCH << 2;
   localparam logic [11:0] A_DIR = GPB_OFS_DIR << 2;
   localparam logic [11:0] A_TIM = GPB_OFS_TIMCFG << 2;
   logic        core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, b, err;
   logic        tim_ch_out = 1'b0, tim_ch_oe = 1'b0, tim_ch_in, tim_ext_clk;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0]  pin_in, pin_out, pin_oe, ext = 4'h5, m_dir, m_lat;
   int          fails = 0, n_tests = 0, seed = 32'hd6ac, k;
   gpb_port gpb_port_i (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tim_ch_out(tim_ch_out),
      .tim_ch_oe(tim_ch_oe), .tim_ch_in(tim_ch_in), .tim_ext_clk(tim_ext_clk), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe));
   gpb_board gpb_board_i (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext), .pin_in(pin_in));
   initial begin
      forever #25 core_clk = ~core_clk;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // The request is held until pready is seen high; a hung slave ends the run.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge core_clk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (pready !== 1'b1) begin
         fails++;
         stop_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   initial begin
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      apb(1'b0, A_DIR, 32'h0);
      check("dir", rd, 32'h0);
      check("oe", 32'(pin_oe), 32'h0);
      apb(1'b0, 12'h0fc, 32'h0);
      check("bad", {rd[30:0], err}, 32'h1);
      for (k = 0; k < 8; k++) begin
         m_lat = 4'($random(seed));
         m_dir = 4'($random(seed));
         ext <= 4'($random(seed));
         apb(1'b1, A_LAT, {28'($random(seed)), m_lat});
         apb(1'b1, A_DIR, {24'($random(seed)), 1'b0, 3'($random(seed)), m_dir});
         apb(1'b0, A_DIR, 32'h0);
         check("dir", rd, 32'(m_dir));
         apb(1'b0, A_LAT, 32'h0);
         check("port", rd, 32'((m_dir & m_lat) | (~m_dir & ext)));
         check("oe", 32'(pin_oe), 32'(m_dir));
         check("out", 32'(pin_out & m_dir), 32'(m_lat & m_dir));
      end
      apb(1'b1, A_DIR, 32'h80);
      apb(1'b0, A_DIR, 32'h0);
      check("clken", rd, 32'h80);
      @(negedge core_clk);
      b = pin_out[0];
      @(negedge core_clk);
      check("mclk", 32'({pin_oe[0], pin_out[0]}), 32'({1'b1, ~b}));
      @(posedge core_clk);
      tim_ch_oe <= 1'b1;
      tim_ch_out <= 1'b1;
      apb(1'b1, A_TIM, 32'h71);
      repeat (4) @(negedge core_clk);
      check("tim", 32'({pin_oe[2], pin_out[2], tim_ch_in, tim_ext_clk}), 32'({3'h7, ext[3]}));
      apb(1'b1, A_TIM, 32'h0);
      repeat (4) @(negedge core_clk);
      check("gpio", 32'({pin_oe[2], tim_ch_in, tim_ext_clk}), 32'h0);
      apb(1'b1, A_LAT, 32'ha);
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      check("oe", 32'(pin_oe), 32'h0);
      apb(1'b1, A_DIR, 32'hf);
      apb(1'b0, A_LAT, 32'h0);
      check("kept", rd, 32'ha);
      stop_test();
   end
endmodule // gpb_port_test
